/* File: logic/afr_pkg.sv */
// Behaviour
// - frame is 256 oscillator ticks from 8-bit counter
// - below high-speed threshold is low-speed ramp mode
// - below rotation threshold the rotor counts stopped
// - low speed: duty rises only at ramp rate
// - two select pins pick one of four rates
// - high speed: analog demand sets duty directly
// - engine start uses ramp from fixed startup duty
// - low-speed ramp duty never below floor duty
// - above regulation maximum keep minimum duty
// - demand from sensed level against internal ramp
// - lamp on undervolt-high-speed, overvolt, stopped rotor
// - load dump forces gate and lamp off
// - key on runs; key off and stopped sleeps
// - lit lamp briefly polled off for key sensing
// - lamp lit delays acting on key-off
// - lamp short: retry lamp at short duty
// - field short: retry gate at short duty
// - wait start delay after key-on before regulating
// - standby holds frame, poll, ramp and duty logic in reset
package afr_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int OSC_HZ = 101_000;
  localparam logic [6:0] OSC_DIV_LAST = 7'(CLK_HZ / OSC_HZ - 1);

  localparam int F1_HZ = 49;
  localparam int F2_HZ = 296;
  localparam logic [11:0] F1_TICKS = 12'(OSC_HZ / F1_HZ);
  localparam logic [11:0] F2_TICKS = 12'(OSC_HZ / F2_HZ);

  localparam int POLL_HZ_X10  = 986;
  localparam int POLL_ON_X100 = 156;
  localparam int POLL_TICKS_I = OSC_HZ * 10 / POLL_HZ_X10;
  localparam logic [9:0] POLL_LAST = 10'(POLL_TICKS_I - 1);
  localparam logic [9:0] POLL_WIN  = 10'((POLL_TICKS_I * POLL_ON_X100 + 9999) / 10000);

  localparam int KEY_OFF_HOLD_US = 10_200;
  localparam logic [10:0] KEY_OFF_HOLD_TICKS = 11'(OSC_HZ / 1000 * KEY_OFF_HOLD_US / 1000);

  localparam int IGN_START_MS = 500;
  localparam int IGN_START_TICKS_DEF = OSC_HZ / 1000 * IGN_START_MS;

  localparam int STARTUP_DUTY_X100 = 3125;
  localparam int MIN_DUTY_X100     = 310;
  localparam logic [7:0] STARTUP_DUTY = 8'((STARTUP_DUTY_X100 * 256 + 9999) / 10000);
  localparam logic [7:0] FLOOR_DUTY   = STARTUP_DUTY;
  localparam logic [7:0] MIN_DUTY     = 8'((MIN_DUTY_X100 * 256 + 9999) / 10000);

  localparam int RATE1_X100 = 931;
  localparam int RATE2_X100 = 1245;
  localparam int RATE3_X100 = 1871;
  localparam int RATE4_X100 = 3742;

  // frames per one-step duty increase for a rate in hundredths of %/s
  function automatic logic [4:0] frames_per_step(input int rate_x100);
    frames_per_step = 5'(OSC_HZ * 10000 / (65536 * rate_x100));
  endfunction : frames_per_step

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_WAKE    = 2'b01,
    ST_START   = 2'b10,
    ST_RUN     = 2'b11
  } afr_mode_t;

  typedef struct packed {
    logic       ign;
    logic       rotor;
    logic       rate_a;
    logic       rate_b;
    logic       under_v;
    logic       over_v;
    logic       above_max;
    logic       load_dump;
    logic       lamp_short;
    logic       field_short;
    logic [7:0] sense;
  } afr_pins_t;

  typedef struct packed {
    logic standby;
    logic waking;
    logic start_ramp;
    logic key_on;
    logic high_speed;
    logic rotor_stopped;
    logic ramp_active;
  } afr_status_t;

endpackage : afr_pkg

/* File: logic/afr_sync.sv */
`timescale 1ns/1ps
module afr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  import afr_pkg::*;

  if (WIDTH < 1) begin : g_bad_width
    $error("afr_sync width must be at least one");
  end

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit changes only once the last two stages agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        dout[i] <= 1'b0;
      end else if (ce && (s2_r[i] == s3_r[i])) begin
        dout[i] <= s3_r[i];
      end
    end
  end

endmodule : afr_sync

/* File: logic/afr_ramp.sv */
`timescale 1ns/1ps
module afr_ramp (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  input  wire logic       clr,
  input  wire logic       frame_end,
  input  wire logic [7:0] demand,
  input  wire logic [4:0] step_frames,
  output logic      [7:0] duty
);
  import afr_pkg::*;

  logic [4:0] step_cnt_r;
  logic       rising;
  logic       step_due;
  logic [7:0] follow;

  assign rising   = demand > duty;
  assign step_due = step_cnt_r >= 5'(step_frames - 5'h01);
  assign follow   = (demand < FLOOR_DUTY) ? FLOOR_DUTY : demand;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      duty       <= STARTUP_DUTY;
      step_cnt_r <= 5'h00;
    end else if (ce) begin
      if (clr) begin
        duty       <= STARTUP_DUTY;
        step_cnt_r <= 5'h00;
      end else if (frame_end && rising) begin
        if (step_due) begin
          duty       <= duty + 8'h01;
          step_cnt_r <= 5'h00;
        end else begin
          step_cnt_r <= step_cnt_r + 5'h01;
        end
      end else if (frame_end) begin
        duty       <= follow;
        step_cnt_r <= 5'h00;
      end
    end
  end

endmodule : afr_ramp

/* File: logic/afr_field_pwm.sv */
`timescale 1ns/1ps
module afr_field_pwm #(
  parameter int IGN_START_TICKS = afr_pkg::IGN_START_TICKS_DEF
) (
  input  wire logic                CLK,
  input  wire logic                RESET_N,
  input  wire logic                CE,
  input  wire logic                IGN_SENSE,
  input  wire logic                ROTOR_PHASE,
  input  wire logic                RATE_SELECT_A,
  input  wire logic                RATE_SELECT_B,
  input  wire logic                UNDER_VOLTAGE,
  input  wire logic                OVER_VOLTAGE,
  input  wire logic                ABOVE_REG_MAX,
  input  wire logic                LOAD_DUMP,
  input  wire logic                LAMP_SHORT,
  input  wire logic                FIELD_SHORT,
  input  wire logic [7:0]          SENSE_LEVEL,
  output logic                     GATE_DRIVE,
  output logic                     LAMP_DRIVE,
  output logic      [7:0]          DUTY,
  output afr_pkg::afr_status_t     STATUS
);
  import afr_pkg::*;

  if (IGN_START_TICKS < 1 || IGN_START_TICKS > 1048575) begin : g_bad_start
    $error("IGN_START_TICKS must lie in 1..1048575");
  end

  localparam logic [19:0] WAKE_LAST = 20'(IGN_START_TICKS - 1);

  // pin capture
  afr_pins_t pins_raw;
  afr_pins_t pins;

  assign pins_raw.ign         = IGN_SENSE;
  assign pins_raw.rotor       = ROTOR_PHASE;
  assign pins_raw.rate_a      = RATE_SELECT_A;
  assign pins_raw.rate_b      = RATE_SELECT_B;
  assign pins_raw.under_v     = UNDER_VOLTAGE;
  assign pins_raw.over_v      = OVER_VOLTAGE;
  assign pins_raw.above_max   = ABOVE_REG_MAX;
  assign pins_raw.load_dump   = LOAD_DUMP;
  assign pins_raw.lamp_short  = LAMP_SHORT;
  assign pins_raw.field_short = FIELD_SHORT;
  assign pins_raw.sense       = SENSE_LEVEL;

  afr_sync #(
    .WIDTH ($bits(afr_pins_t))
  ) u_sync (
    .clk     (CLK),
    .reset_n (RESET_N),
    .ce      (CE),
    .din     (pins_raw),
    .dout    (pins)
  );

  // state
  afr_mode_t   state_r;
  afr_mode_t   state_nxt;
  logic [6:0]  osc_div_r;
  logic [7:0]  frame_cnt_r;
  logic [9:0]  poll_cnt_r;
  logic [11:0] period_cnt_r;
  logic        rotor_prev_r;
  logic        stopped_r;
  logic        high_r;
  logic        key_on_r;
  logic [10:0] hold_cnt_r;
  logic [19:0] wake_cnt_r;
  logic        lamp_req_r;
  logic [7:0]  duty_r;
  logic        gate_r;
  logic        lamp_r;

  // decode
  logic        osc_tick;
  logic        frame_end;
  logic        poll_end;
  logic        poll_win;
  logic        in_standby;
  logic        in_wake;
  logic        in_start;
  logic        rotor_rise;
  logic        period_over;
  logic        key_hold;
  logic        wake_done;
  logic        ramp_mode;
  logic        ramp_clr;
  logic        gate_allow;
  logic        gate_pwm;
  logic        lamp_req_nxt;
  logic        gate_nxt;
  logic        lamp_nxt;
  logic [1:0]  rate_sel;
  logic [4:0]  step_frames;
  logic [7:0]  demand;
  logic [7:0]  ramp_duty;
  logic [7:0]  limited;
  logic [7:0]  lrc_duty;
  logic [7:0]  base_duty;
  logic [7:0]  duty_nxt;

  assign osc_tick   = CE && (osc_div_r == OSC_DIV_LAST);
  assign frame_end  = osc_tick && (frame_cnt_r == 8'hFF);
  assign poll_end   = osc_tick && (poll_cnt_r == POLL_LAST);
  assign poll_win   = poll_cnt_r < POLL_WIN;
  assign in_standby = state_r == ST_STANDBY;
  assign in_wake    = state_r == ST_WAKE;
  assign in_start   = state_r == ST_START;

  assign rotor_rise  = pins.rotor && !rotor_prev_r;
  assign period_over = period_cnt_r > F1_TICKS;

  assign key_hold  = key_on_r && lamp_req_r && (hold_cnt_r < KEY_OFF_HOLD_TICKS);
  assign wake_done = osc_tick && (wake_cnt_r >= WAKE_LAST);

  // open select pin reads high
  assign rate_sel = {pins.rate_b, pins.rate_a};
  assign step_frames = (rate_sel == 2'b00) ? frames_per_step(RATE1_X100) :
                       (rate_sel == 2'b01) ? frames_per_step(RATE2_X100) :
                       (rate_sel == 2'b10) ? frames_per_step(RATE3_X100) :
                                             frames_per_step(RATE4_X100);

  // low sensed level asks for long on time
  assign demand = ~pins.sense;

  assign ramp_mode = in_start || !high_r;
  assign ramp_clr  = in_standby || in_wake;

  afr_ramp u_ramp (
    .clk         (CLK),
    .reset_n     (RESET_N),
    .ce          (CE),
    .clr         (ramp_clr),
    .frame_end   (frame_end),
    .demand      (demand),
    .step_frames (step_frames),
    .duty        (ramp_duty)
  );

  assign limited   = (demand < ramp_duty) ? demand : ramp_duty;
  assign lrc_duty  = (limited < FLOOR_DUTY) ? FLOOR_DUTY : limited;
  assign base_duty = ramp_mode ? lrc_duty : demand;
  assign duty_nxt  = !pins.above_max   ? base_duty :
                     (demand < MIN_DUTY) ? MIN_DUTY : demand;

  assign gate_allow = (state_r == ST_START) || (state_r == ST_RUN);
  assign gate_pwm   = frame_cnt_r < duty_r;

  assign lamp_req_nxt = (pins.under_v && high_r) || pins.over_v || stopped_r;

  assign gate_nxt = gate_allow && gate_pwm && !pins.load_dump
                    && (!pins.field_short || poll_win);
  assign lamp_nxt = lamp_req_r && !in_standby && !pins.load_dump
                    && (pins.lamp_short ? poll_win : !poll_win);

  // mode sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_STANDBY: begin
        if (key_on_r) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_done) begin
          state_nxt = ST_START;
        end
      end
      ST_START: begin
        if (frame_end && (demand <= ramp_duty)) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
    endcase
    if (!in_standby && !key_on_r && stopped_r) begin
      state_nxt = ST_STANDBY;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= ST_STANDBY;
    end else if (CE) begin
      state_r <= state_nxt;
    end
  end

  // oscillator tick and frame counter
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      osc_div_r   <= 7'h00;
      frame_cnt_r <= 8'h00;
    end else if (CE) begin
      osc_div_r <= (osc_div_r == OSC_DIV_LAST) ? 7'h00 : osc_div_r + 7'h01;
      if (in_standby) begin
        frame_cnt_r <= 8'h00;
      end else if (osc_tick) begin
        frame_cnt_r <= frame_cnt_r + 8'h01;
      end
    end
  end

  // lamp and fault polling timer
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      poll_cnt_r <= 10'h000;
    end else if (CE) begin
      if (in_standby || poll_end) begin
        poll_cnt_r <= 10'h000;
      end else if (osc_tick) begin
        poll_cnt_r <= poll_cnt_r + 10'h001;
      end
    end
  end

  // rotor period in oscillator ticks, kept alive in standby for sleep decisions
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rotor_prev_r <= 1'b0;
      period_cnt_r <= 12'h000;
      stopped_r    <= 1'b1;
      high_r       <= 1'b0;
    end else if (CE) begin
      rotor_prev_r <= pins.rotor;
      if (rotor_rise) begin
        stopped_r    <= period_over;
        high_r       <= period_cnt_r < F2_TICKS;
        period_cnt_r <= 12'h000;
      end else begin
        if (period_over) begin
          stopped_r <= 1'b1;
          high_r    <= 1'b0;
        end
        if (osc_tick && !period_over) begin
          period_cnt_r <= period_cnt_r + 12'h001;
        end
      end
    end
  end

  // key sense with off-delay while the lamp is lit
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      key_on_r   <= 1'b0;
      hold_cnt_r <= 11'h000;
    end else if (CE) begin
      if (pins.ign) begin
        key_on_r   <= 1'b1;
        hold_cnt_r <= 11'h000;
      end else if (key_hold) begin
        hold_cnt_r <= osc_tick ? hold_cnt_r + 11'h001 : hold_cnt_r;
      end else begin
        key_on_r   <= 1'b0;
        hold_cnt_r <= 11'h000;
      end
    end
  end

  // start delay after key-on
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wake_cnt_r <= 20'h00000;
    end else if (CE) begin
      if (!in_wake) begin
        wake_cnt_r <= 20'h00000;
      end else if (osc_tick && !wake_done) begin
        wake_cnt_r <= wake_cnt_r + 20'h00001;
      end
    end
  end

  // duty latched once per frame, outputs registered
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      duty_r     <= 8'h00;
      lamp_req_r <= 1'b0;
      gate_r     <= 1'b0;
      lamp_r     <= 1'b0;
    end else if (CE) begin
      if (in_standby) begin
        duty_r <= 8'h00;
      end else if (frame_end) begin
        duty_r <= duty_nxt;
      end
      lamp_req_r <= !in_standby && lamp_req_nxt;
      gate_r     <= gate_nxt;
      lamp_r     <= lamp_nxt;
    end
  end

  assign GATE_DRIVE = gate_r;
  assign LAMP_DRIVE = lamp_r;
  assign DUTY       = duty_r;

  assign STATUS.standby       = in_standby;
  assign STATUS.waking        = in_wake;
  assign STATUS.start_ramp    = in_start;
  assign STATUS.key_on        = key_on_r;
  assign STATUS.high_speed    = high_r;
  assign STATUS.rotor_stopped = stopped_r;
  assign STATUS.ramp_active   = ramp_mode && gate_allow;

endmodule : afr_field_pwm

/* File: sim/afr_field_pwm_properties.sv */
`timescale 1ns/1ps
module afr_field_pwm_checker #(
  parameter int IGN_START_TICKS = afr_pkg::IGN_START_TICKS_DEF
) (
  input wire logic                CLK,
  input wire logic                RESET_N,
  input wire logic                CE,
  input wire logic                IGN_SENSE,
  input wire logic                ROTOR_PHASE,
  input wire logic                RATE_SELECT_A,
  input wire logic                RATE_SELECT_B,
  input wire logic                UNDER_VOLTAGE,
  input wire logic                OVER_VOLTAGE,
  input wire logic                ABOVE_REG_MAX,
  input wire logic                LOAD_DUMP,
  input wire logic                LAMP_SHORT,
  input wire logic                FIELD_SHORT,
  input wire logic [7:0]          SENSE_LEVEL,
  input wire logic                GATE_DRIVE,
  input wire logic                LAMP_DRIVE,
  input wire logic [7:0]          DUTY,
  input wire afr_pkg::afr_status_t STATUS
);
  import afr_pkg::*;
  // retry window plus input sync lag
  localparam int WIN_CLK  = 1600;
  localparam int WAKE_MAX = IGN_START_TICKS * 99 + 99;
  int fs_run_r;
  int ls_run_r;
  int wake_run_r;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fs_run_r   <= 0;
      ls_run_r   <= 0;
      wake_run_r <= 0;
    end else begin
      fs_run_r   <= (GATE_DRIVE && FIELD_SHORT) ? fs_run_r + 1 : 0;
      ls_run_r   <= (LAMP_DRIVE && LAMP_SHORT) ? ls_run_r + 1 : 0;
      wake_run_r <= STATUS.waking ? wake_run_r + 1 : 0;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  chk_dump_all_off: assert property (
    LOAD_DUMP [*6] |-> !GATE_DRIVE && !LAMP_DRIVE) else $error("drive during load dump");
  chk_standby_idle: assert property (
    STATUS.standby && $past(STATUS.standby) |-> !GATE_DRIVE && DUTY == 8'h00)
    else $error("activity in standby");
  chk_wake_no_gate: assert property (
    STATUS.waking && $past(STATUS.waking) |-> !GATE_DRIVE) else $error("gate while waking");
  chk_wake_bounded: assert property (
    wake_run_r <= WAKE_MAX) else $error("start delay too long");
  chk_key_wakes: assert property (
    STATUS.standby && STATUS.key_on && CE |=> STATUS.waking) else $error("key on ignored");
  chk_start_order: assert property (
    $rose(STATUS.start_ramp) |-> $past(STATUS.waking)) else $error("start not from wake");
  chk_gate_duty: assert property (
    GATE_DRIVE |-> $past(DUTY) != 8'h00) else $error("gate with zero duty");
  chk_field_retry: assert property (
    fs_run_r <= WIN_CLK) else $error("field retry too long");
  chk_lamp_retry: assert property (
    ls_run_r <= WIN_CLK) else $error("lamp retry too long");
endmodule : afr_field_pwm_checker

bind afr_field_pwm afr_field_pwm_checker #(.IGN_START_TICKS(IGN_START_TICKS)) chk_u (
  .CLK(CLK), .RESET_N(RESET_N), .CE(CE), .IGN_SENSE(IGN_SENSE), .ROTOR_PHASE(ROTOR_PHASE),
  .RATE_SELECT_A(RATE_SELECT_A), .RATE_SELECT_B(RATE_SELECT_B),
  .UNDER_VOLTAGE(UNDER_VOLTAGE), .OVER_VOLTAGE(OVER_VOLTAGE), .ABOVE_REG_MAX(ABOVE_REG_MAX),
  .LOAD_DUMP(LOAD_DUMP), .LAMP_SHORT(LAMP_SHORT), .FIELD_SHORT(FIELD_SHORT),
  .SENSE_LEVEL(SENSE_LEVEL), .GATE_DRIVE(GATE_DRIVE), .LAMP_DRIVE(LAMP_DRIVE),
  .DUTY(DUTY), .STATUS(STATUS));

/* File: sim/afr_alt_model.sv */
`timescale 1ns/1ps
module afr_alt_model #(
  parameter int HALF = 4950
) (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic key,
  input  wire logic lamp,
  output logic      rotor_phase,
  output logic      ign_sense
);
  int half_cnt;
  // lamp on pulls the sense node low; shunt keeps it high otherwise
  assign ign_sense = key & ~lamp;
  always_ff @(posedge clk) begin
    if (!run) begin
      half_cnt    <= 0;
      rotor_phase <= 1'b0;
    end else if (half_cnt == HALF - 1) begin
      half_cnt    <= 0;
      rotor_phase <= ~rotor_phase;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end
endmodule : afr_alt_model

/* File: sim/alternator_field_pwm_lrc_bench.sv */
`timescale 1ns/1ps
module alternator_field_pwm_lrc_bench;
  import afr_pkg::*;
  logic        clk, reset_n, key, run, ld, ov, fs, ra, rb, gate, lamp, ign, rot;
  logic        uv, am, ls;
  logic [7:0]  sense, duty;
  afr_status_t st;
  logic [31:0] seed;
  int          mismatches, checks_done, cyc, n1, n2;

  afr_alt_model model_u (.clk(clk), .run(run), .key(key), .lamp(lamp),
    .rotor_phase(rot), .ign_sense(ign));
  afr_field_pwm #(.IGN_START_TICKS(20)) dut_u (
    .CLK(clk), .RESET_N(reset_n), .CE(1'b1), .IGN_SENSE(ign), .ROTOR_PHASE(rot),
    .RATE_SELECT_A(ra), .RATE_SELECT_B(rb), .UNDER_VOLTAGE(uv), .OVER_VOLTAGE(ov),
    .ABOVE_REG_MAX(am), .LOAD_DUMP(ld), .LAMP_SHORT(ls), .FIELD_SHORT(fs),
    .SENSE_LEVEL(sense), .GATE_DRIVE(gate), .LAMP_DRIVE(lamp), .DUTY(duty), .STATUS(st));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction : xs

  function automatic int exp_clks(input int ticks);
    exp_clks = ticks * (int'(OSC_DIV_LAST) + 1);
  endfunction : exp_clks

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick

  // cycles until gate reaches lvl, bounded
  task automatic wait_gate(input logic lvl, output int n);
    n = 0;
    while (gate !== lvl && n < 30000) begin
      tick(1);
      n++;
    end
    // a gate that never moves counts against the run
    if (gate !== lvl) begin
      mismatches++;
    end
  endtask : wait_gate

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    reset_n = 1'b0;
    key = 1'b0;
    run = 1'b0;
    ld = 1'b0;
    ov = 1'b0;
    fs = 1'b0;
    uv = 1'b0;
    am = 1'b0;
    ls = 1'b0;
    seed = xs(32'h0000D3B3);
    // demand stays far above the startup duty
    sense = {2'b00, seed[5:0]};
    ra = seed[8];
    rb = seed[9];
    tick(2);
    reset_n = 1'b1;
    tick(1);
    check("standby", 16'(st.standby), 16'h0001);
    check("gate_rst", 16'(gate), 16'h0000);
    $display("[TEST] reset done");
    key = 1'b1;
    tick(10);
    check("waking", 16'(st.waking), 16'h0001);
    tick(exp_clks(8));
    check("lamp_poll", 16'(lamp), 16'h0000);
    tick(exp_clks(10));
    check("lamp_stop", 16'(lamp), 16'h0001);
    check("start_early", 16'(st.start_ramp), 16'h0000);
    check("key_hold", 16'(st.key_on), 16'h0001);
    run = 1'b1;
    tick(2000);
    check("start", 16'(st.start_ramp), 16'h0001);
    check("gate_wait", 16'(gate), 16'h0000);
    $display("[TEST] wake done");
    wait_gate(1'b1, n1);
    check("duty_start", 16'(duty), 16'(STARTUP_DUTY));
    wait_gate(1'b0, n1);
    check("high_clks", 16'(n1), 16'(exp_clks(int'(STARTUP_DUTY))));
    wait_gate(1'b1, n2);
    check("frame_clks", 16'(n1 + n2), 16'(exp_clks(256)));
    check("duty_ramp", 16'(duty), 16'(STARTUP_DUTY));
    check("high_speed", 16'(st.high_speed), 16'h0001);
    check("rotating", 16'(st.rotor_stopped), 16'h0000);
    check("start_hold", 16'(st.start_ramp), 16'h0001);
    $display("[TEST] frame done");
    tick(100);
    ld = 1'b1;
    tick(6);
    check("dump_gate", 16'(gate), 16'h0000);
    check("dump_lamp", 16'(lamp), 16'h0000);
    ld = 1'b0;
    tick(10);
    check("gate_back", 16'(gate), 16'h0001);
    check("lamp_quiet", 16'(lamp), 16'h0000);
    ov = 1'b1;
    tick(20);
    check("lamp_over", 16'(lamp), 16'h0001);
    ov = 1'b0;
    tick(20);
    check("lamp_clear", 16'(lamp), 16'h0000);
    uv = 1'b1;
    tick(20);
    check("lamp_under", 16'(lamp), 16'h0001);
    ls = 1'b1;
    tick(20);
    check("lamp_short", 16'(lamp), 16'h0000);
    ls = 1'b0;
    uv = 1'b0;
    fs = 1'b1;
    tick(3000);
    check("field_short", 16'(gate), 16'h0000);
    fs = 1'b0;
    tick(10);
    $display("[TEST] faults done");
    // regulation maximum exceeded: demand drops to zero, minimum duty stays
    am = 1'b1;
    sense = 8'hFF;
    wait_gate(1'b0, n1);
    wait_gate(1'b1, n1);
    check("duty_min", 16'(duty), 16'(MIN_DUTY));
    check("ramp_off", 16'(st.ramp_active), 16'h0000);
    wait_gate(1'b0, n1);
    check("min_clks", 16'(n1), 16'(exp_clks(int'(MIN_DUTY))));
    $display("[TEST] minimum duty done");
    close_out();
  end
endmodule : alternator_field_pwm_lrc_bench
